// ### design/rom_pkg.sv
// shared constants for the expansion rom image and its host reader
package rom_pkg;
   // ************************************************
   // window and image geometry
   // ************************************************
   localparam int          ROM_BYTES      = 16384;
   localparam int          ROM_AW         = 14;
   localparam int          IMG_BYTES      = 4096;
   localparam logic [13:0] X86_BASE       = 14'h0000;
   localparam logic [13:0] OFW_BASE       = 14'h1000;
   localparam int          UNIT_BYTES     = 512;
   // ************************************************
   // header field offsets inside one image
   // ************************************************
   localparam logic [11:0] OFF_SIG0       = 12'h000;
   localparam logic [11:0] OFF_SIG1       = 12'h001;
   localparam logic [11:0] OFF_INIT_SIZE  = 12'h002;
   localparam logic [11:0] OFF_ENTRY      = 12'h003;
   localparam logic [11:0] OFF_FCODE_PTR  = 12'h002;
   localparam logic [11:0] OFF_DS_PTR     = 12'h018;
   localparam logic [11:0] DS_OFFSET      = 12'h020;
   localparam logic [11:0] FCODE_OFFSET   = 12'h040;
   // ************************************************
   // data structure field offsets and values
   // ************************************************
   localparam logic [4:0]  DS_SIG         = 5'h00;
   localparam logic [4:0]  DS_VENDOR      = 5'h04;
   localparam logic [4:0]  DS_DEVICE      = 5'h06;
   localparam logic [4:0]  DS_VPD         = 5'h08;
   localparam logic [4:0]  DS_LEN         = 5'h0a;
   localparam logic [4:0]  DS_REV         = 5'h0c;
   localparam logic [4:0]  DS_CLASS       = 5'h0d;
   localparam logic [4:0]  DS_IMG_LEN     = 5'h10;
   localparam logic [4:0]  DS_CODE_REV    = 5'h12;
   localparam logic [4:0]  DS_CODE_TYPE   = 5'h14;
   localparam logic [4:0]  DS_INDICATOR   = 5'h15;
   localparam logic [7:0]  SIG_BYTE0      = 8'h55;
   localparam logic [7:0]  SIG_BYTE1      = 8'haa;
   localparam logic [31:0] PCIR_WORD      = 32'h52494350;
   localparam logic [15:0] VPD_NONE       = 16'h0000;
   localparam logic [15:0] DS_LENGTH      = 16'h0018;
   localparam logic [7:0]  DS_REVISION    = 8'h00;
   localparam logic [23:0] CLASS_CODE     = 24'h00020c;
   localparam logic [15:0] IMG_UNITS      = 16'h0008;
   localparam logic [7:0]  CODE_X86       = 8'h00;
   localparam logic [7:0]  CODE_OFW       = 8'h01;
   localparam logic [7:0]  LAST_IMAGE     = 8'h80;
   localparam logic [7:0]  NOT_LAST       = 8'h00;
   localparam logic [7:0]  X86_UNITS      = 8'h08;
   // ************************************************
   // boot policy and host register map
   // ************************************************
   localparam logic [7:0]  ARRAY_BOOT_LVL = 8'd50;
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_STATUS     = 12'h004;
   localparam logic [11:0] REG_ADDR       = 12'h008;
   localparam logic [11:0] REG_DATA       = 12'h00c;
   localparam logic [11:0] REG_SCAN       = 12'h010;
   localparam logic [11:0] REG_TARGET     = 12'h014;
   localparam logic [11:0] REG_RESULT     = 12'h018;
   typedef enum logic [1:0] {OP_READY_TEST, OP_TEST, OP_READ} boot_op_e;
endpackage : rom_pkg

// ### design/rom_link_if.sv
// interface joining the rom window to the host reader
`timescale 1ns/1ps
interface rom_link_if;
   import rom_pkg::*;
   logic [31:0] rom_base;  // programmed expansion rom base
   logic        mem_req;   // memory cycle strobe
   logic        mem_we;    // write (ignored by rom)
   logic [31:0] mem_addr;
   logic [31:0] mem_wdata;
   logic        mem_ack;   // one-cycle answer
   logic [31:0] mem_rdata;
   logic        io_req;    // execute i/o operation strobe
   boot_op_e    io_op;
   logic [2:0]  io_disk;
   logic        io_ack;
   logic [3:0]  io_count;  // ready test: resources
   logic [31:0] io_serial; // test: serial of disk
   logic        io_array;  // test: disk is an array
   logic        io_ok;     // operation allowed
   modport device (input rom_base, mem_req, mem_we, mem_addr, mem_wdata, io_req, io_op,
                   io_disk, output mem_ack, mem_rdata, io_ack, io_count, io_serial,
                   io_array, io_ok);
   modport host (output rom_base, mem_req, mem_we, mem_addr, mem_wdata, io_req, io_op,
                 io_disk, input mem_ack, mem_rdata, io_ack, io_count, io_serial,
                 io_array, io_ok);
endinterface : rom_link_if

// ### design/rom_device.sv
// adapter end: flash-backed expansion rom window and boot gate
`timescale 1ns/1ps
module rom_device
   import rom_pkg::*;
#(
   parameter logic [15:0] VENDOR_CODE = 16'h0a0a, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0b0b, // arbitrary value
   parameter logic [7:0]  CODE_LEVEL  = 8'd50,
   parameter int          DISKS       = 8
)(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // host link
   rom_link_if.device link,
   // microcode download port
   input  wire logic        dl_we,
   input  wire logic [13:0] dl_addr,
   input  wire logic [7:0]  dl_data,
   input  wire logic        dl_done,
   // disk table for boot tests
   input  wire logic [DISKS-1:0]   disk_present,
   input  wire logic [DISKS-1:0]   disk_is_array,
   input  wire logic [DISKS*32-1:0] disk_serial,
   // status
   output logic             image_valid
);
   // ************************************************
   // flash array and default image
   // ************************************************
   logic [7:0] flash_q [ROM_BYTES];

   // byte of a factory image at a window offset
   function automatic logic [7:0] image_byte(input logic [13:0] a);
      logic        ofw;
      logic [11:0] o;
      logic [4:0]  d;
      ofw = a[12];
      o   = a[11:0];
      d   = o[4:0] - DS_OFFSET[4:0];
      image_byte = 8'h00;
      if (a[13]) image_byte = 8'hff;
      else if (o == OFF_SIG0) image_byte = SIG_BYTE0;
      else if (o == OFF_SIG1) image_byte = SIG_BYTE1;
      else if (!ofw && o == OFF_INIT_SIZE) image_byte = X86_UNITS;
      else if (!ofw && o == OFF_ENTRY) image_byte = 8'hcb;
      else if (!ofw && o == OFF_ENTRY + 12'h001) image_byte = FCODE_OFFSET[7:0];
      else if (ofw && o == OFF_FCODE_PTR) image_byte = FCODE_OFFSET[7:0];
      else if (ofw && o == OFF_FCODE_PTR + 12'h001) image_byte = {4'h0, FCODE_OFFSET[11:8]};
      else if (o == OFF_DS_PTR) image_byte = DS_OFFSET[7:0];
      else if (o == OFF_DS_PTR + 12'h001) image_byte = {4'h0, DS_OFFSET[11:8]};
      else if (o >= DS_OFFSET && o < DS_OFFSET + 12'h018)
      begin
         if (d < DS_VENDOR) image_byte = PCIR_WORD[d[1:0]*8 +: 8];
         else if (d < DS_DEVICE) image_byte = VENDOR_CODE[d[0]*8 +: 8];
         else if (d < DS_VPD) image_byte = DEVICE_CODE[d[0]*8 +: 8];
         else if (d < DS_LEN) image_byte = VPD_NONE[d[0]*8 +: 8];
         else if (d < DS_REV) image_byte = DS_LENGTH[d[0]*8 +: 8];
         else if (d == DS_REV) image_byte = DS_REVISION;
         else if (d < DS_IMG_LEN) image_byte = CLASS_CODE[(d - DS_CLASS)*8 +: 8];
         else if (d < DS_CODE_REV) image_byte = IMG_UNITS[d[0]*8 +: 8];
         else if (d == DS_CODE_TYPE) image_byte = ofw ? CODE_OFW : CODE_X86;
         else if (d == DS_INDICATOR) image_byte = ofw ? LAST_IMAGE : NOT_LAST;
      end
      else if (!ofw && o == 12'hfff) image_byte = 8'h00; // checksum slot
   endfunction : image_byte

   // flash contents: factory image on reset, download rewrites, host writes dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < ROM_BYTES; i++) flash_q[i] <= image_byte(14'(i));
      end
      else if (dl_we)
      begin
         flash_q[dl_addr] <= dl_data;
      end
   end
   // host memory writes have no path into flash_q

   // ************************************************
   // memory read path
   // ************************************************
   logic        hit;
   logic [13:0] off;
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic        valid_q, valid_d;

   always_comb
   begin
      off     = 14'(link.mem_addr - link.rom_base);
      hit     = (link.mem_addr >= link.rom_base) &&
                (link.mem_addr - link.rom_base < 32'(ROM_BYTES));
      ack_d   = link.mem_req;
      rdata_d = 32'h0;
      if (link.mem_req && !link.mem_we && hit)
         rdata_d = {flash_q[{off[13:2], 2'b11}], flash_q[{off[13:2], 2'b10}],
                    flash_q[{off[13:2], 2'b01}], flash_q[{off[13:2], 2'b00}]};
      valid_d = dl_we ? 1'b0 : (dl_done ? 1'b1 : valid_q);
   end

   // ************************************************
   // execute i/o boot operations
   // ************************************************
   logic        io_ack_q, io_ack_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [31:0] ser_q, ser_d;
   logic        arr_q, arr_d;
   logic        ok_q, ok_d;

   always_comb
   begin
      io_ack_d = link.io_req;
      cnt_d    = cnt_q;
      ser_d    = ser_q;
      arr_d    = arr_q;
      ok_d     = ok_q;
      if (link.io_req)
      begin
         case (link.io_op)
            OP_READY_TEST:
            begin
               cnt_d = 4'($countones(disk_present));
               ok_d  = 1'b1;
            end
            OP_TEST:
            begin
               ser_d = disk_serial[link.io_disk*32 +: 32];
               arr_d = disk_is_array[link.io_disk];
               ok_d  = disk_present[link.io_disk];
            end
            default:
            begin
               // arrays boot only from level 50 on
               ok_d = disk_present[link.io_disk] &&
                      (!disk_is_array[link.io_disk] || CODE_LEVEL >= ARRAY_BOOT_LVL);
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_q    <= 1'b0;
         rdata_q  <= 32'h0;
         valid_q  <= 1'b1;
         io_ack_q <= 1'b0;
         cnt_q    <= 4'h0;
         ser_q    <= 32'h0;
         arr_q    <= 1'b0;
         ok_q     <= 1'b0;
      end
      else
      begin
         ack_q    <= ack_d;
         rdata_q  <= rdata_d;
         valid_q  <= valid_d;
         io_ack_q <= io_ack_d;
         cnt_q    <= cnt_d;
         ser_q    <= ser_d;
         arr_q    <= arr_d;
         ok_q     <= ok_d;
      end
   end

   assign link.mem_ack   = ack_q;
   assign link.mem_rdata = rdata_q;
   assign link.io_ack    = io_ack_q;
   assign link.io_count  = cnt_q;
   assign link.io_serial = ser_q;
   assign link.io_array  = arr_q;
   assign link.io_ok     = ok_q;
   assign image_valid    = valid_q; // low while a download is open
endmodule : rom_device

// ### design/rom_host.sv
// host end: apb-driven rom reader and boot sequencer
`timescale 1ns/1ps
module rom_host
   import rom_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link to adapter
   rom_link_if.host link
);
   // ************************************************
   // registers and boot sequencer
   // ************************************************
   typedef enum {S_IDLE, S_MEM, S_READY, S_SCAN, S_READ, S_DONE} st_e;
   st_e         st_q, st_d;
   logic [31:0] base_q, base_d, addr_q, addr_d, data_q, data_d, tgt_q, tgt_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [2:0]  disk_q, disk_d;
   logic        found_q, found_d, ok_q, ok_d, wr_q, wr_d, req_q, req_d;
   logic [31:0] prdata_d;
   logic        acc;

   always_comb
   begin
      acc = psel && penable;
      {st_d, base_d, addr_d, data_d, tgt_d} = {st_q, base_q, addr_q, data_q, tgt_q};
      {cnt_d, disk_d, found_d, ok_d, wr_d} = {cnt_q, disk_q, found_q, ok_q, wr_q};
      req_d    = 1'b0;
      prdata_d = 32'h0;
      if (psel && !penable && !pwrite) // decoded in setup so prdata stands in access
      begin
         if (paddr == REG_STATUS) prdata_d = {29'h0, ok_q, found_q, st_q == S_IDLE};
         else if (paddr == REG_CTRL) prdata_d = base_q;
         else if (paddr == REG_ADDR) prdata_d = addr_q;
         else if (paddr == REG_DATA) prdata_d = data_q;
         else if (paddr == REG_SCAN) prdata_d = {28'h0, cnt_q};
         else if (paddr == REG_TARGET) prdata_d = tgt_q;
         else if (paddr == REG_RESULT) prdata_d = {29'h0, disk_q};
      end
      case (st_q)
         S_IDLE:
         begin
            if (acc && pwrite && paddr == REG_CTRL) base_d = pwdata;
            else if (acc && pwrite && paddr == REG_TARGET) tgt_d = pwdata;
            else if (acc && pwrite && paddr == REG_DATA)
            begin
               data_d = pwdata;
               wr_d   = 1'b1;
               req_d  = 1'b1;
               st_d   = S_MEM;
            end
            else if (acc && pwrite && paddr == REG_ADDR)
            begin
               addr_d = pwdata;
               wr_d   = 1'b0;
               req_d  = 1'b1;
               st_d   = S_MEM;
            end
            else if (acc && pwrite && paddr == REG_SCAN)
            begin
               {found_d, ok_d, disk_d} = 5'h0;
               req_d = 1'b1;
               st_d  = S_READY;
            end
         end
         S_MEM:
            if (link.mem_ack)
            begin
               if (!wr_q) data_d = link.mem_rdata;
               st_d = S_IDLE;
            end
         S_READY:
            if (link.io_ack)
            begin
               cnt_d = link.io_count;
               req_d = 1'b1;
               st_d  = S_SCAN;
            end
         S_SCAN:
            if (link.io_ack)
            begin
               req_d = 1'b1;
               if (link.io_ok && link.io_serial == tgt_q)
               begin
                  found_d = 1'b1;
                  st_d    = S_READ;
               end
               else if (disk_q == 3'h7) begin req_d = 1'b0; st_d = S_DONE; end
               else disk_d = disk_q + 3'h1;
            end
         S_READ:
            if (link.io_ack) begin ok_d = link.io_ok; st_d = S_DONE; end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= S_IDLE;
         {base_q, addr_q, data_q, tgt_q} <= 128'h0;
         {cnt_q, disk_q, found_q, ok_q, wr_q, req_q} <= 11'h0;
         prdata <= 32'h0;
      end
      else
      begin
         st_q <= st_d;
         {base_q, addr_q, data_q, tgt_q} <= {base_d, addr_d, data_d, tgt_d};
         {cnt_q, disk_q, found_q, ok_q, wr_q, req_q} <= {cnt_d, disk_d, found_d, ok_d, wr_d,
                                                          req_d};
         prdata <= prdata_d;
      end
   end

   assign pready         = 1'b1;
   assign pslverr        = 1'b0;
   assign link.rom_base  = base_q;
   assign link.mem_req   = req_q && st_q == S_MEM;
   assign link.mem_we    = wr_q;
   assign link.mem_addr  = addr_q;
   assign link.mem_wdata = data_q;
   assign link.io_req    = req_q && st_q != S_MEM;
   assign link.io_op     = st_q == S_READY ? OP_READY_TEST : (st_q == S_SCAN ? OP_TEST : OP_READ);
   assign link.io_disk   = disk_q;
endmodule : rom_host

// ### verification/rom_link_asserts.sv
// concurrent checks on the link between the host reader and the rom window
`timescale 1ns/1ps
module rom_link_asserts
   import rom_pkg::*;
#(
   parameter logic [15:0] VENDOR_CODE = 16'h0a0a, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0b0b  // arbitrary value
)(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // memory side of the link
   input wire logic [31:0] rom_base,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_rdata,
   // execute i/o side of the link
   input wire logic        io_req,
   input wire boot_op_e    io_op,
   input wire logic        io_ack,
   input wire logic        io_ok
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ************************************************
   // window offset of the current request
   // ************************************************
   logic [31:0] off; // wraps huge below the base, so one compare covers both sides
   assign off = (mem_addr - rom_base) & 32'hffff_fffc;
   // a read of word o in either image answers v one cycle later
   property p_word(logic [31:0] o, logic [31:0] v);
      mem_req && !mem_we && (off == o || off == o + 32'h1000) |=> mem_rdata == v;
   endproperty
   // ************************************************
   // answers and image contents
   // ************************************************
   a_mem_answer: assert property (mem_req |=> mem_ack)
      else $error("memory request without answer");
   a_ack_cause: assert property (mem_ack |-> $past(mem_req))
      else $error("memory answer without request");
   a_io_answer: assert property (io_req |=> io_ack)
      else $error("i/o request without answer");
   a_sig_bytes: assert property (mem_req && !mem_we && (off == 0 || off == 32'h1000)
      |=> mem_rdata[15:0] == {SIG_BYTE1, SIG_BYTE0})
      else $error("image signature wrong");
   a_x86_size: assert property (mem_req && !mem_we && off == 0
      |=> mem_rdata[23:16] == X86_UNITS)
      else $error("x86 size byte wrong");
   a_fcode_ptr: assert property (mem_req && !mem_we && off == 32'h1000
      |=> mem_rdata[31:16] == {4'h0, FCODE_OFFSET})
      else $error("fcode pointer wrong");
   a_ds_pointer: assert property (mem_req && !mem_we && (off == 32'h18 || off == 32'h1018)
      |=> mem_rdata[15:0] == {4'h0, DS_OFFSET})
      else $error("data structure pointer wrong");
   a_pcir_word: assert property (p_word(32'h20, PCIR_WORD))
      else $error("structure signature wrong");
   a_ident_codes: assert property (p_word(32'h24, {DEVICE_CODE, VENDOR_CODE}))
      else $error("identification codes wrong");
   a_vpd_length: assert property (p_word(32'h28, {DS_LENGTH, VPD_NONE}))
      else $error("vpd pointer or length wrong");
   a_rev_class: assert property (p_word(32'h2c, {CLASS_CODE, DS_REVISION}))
      else $error("revision or class code wrong");
   a_image_units: assert property (p_word(32'h30, {16'h0000, IMG_UNITS}))
      else $error("image length wrong");
   a_x86_type: assert property (mem_req && !mem_we && off == 32'h34
      |=> mem_rdata[15:0] == {NOT_LAST, CODE_X86})
      else $error("x86 code type or indicator wrong");
   a_ofw_last: assert property (mem_req && !mem_we && off == 32'h1034
      |=> mem_rdata[15:0] == {LAST_IMAGE, CODE_OFW})
      else $error("fcode code type or indicator wrong");
   a_outside_zero: assert property (mem_req && !mem_we && off >= 32'h4000
      |=> mem_rdata == 32'h0000_0000)
      else $error("read outside window not zero");
   // main scenarios
   c_rom_write: cover property (mem_req && mem_we);
   c_read_op: cover property (io_req && io_op == OP_READ);
   c_boot_ok: cover property (io_ack && io_ok);
endmodule : rom_link_asserts

// ### verification/tb_pci_expansion_rom_image.sv
// self-checking bench for the rom window and its host reader
`timescale 1ns/1ps
module tb_pci_expansion_rom_image;
   import rom_pkg::*;
   localparam logic [15:0] VEND  = 16'h3c5a; // arbitrary value
   localparam logic [15:0] DEVC  = 16'h7e21; // arbitrary value
   localparam int          LIMIT = 30000;    // run needs well under this
   localparam logic [13:0] OFFS [18] = '{14'h0000, 14'h0018, 14'h0020, 14'h0024, 14'h0028,
      14'h002c, 14'h0030, 14'h0034, 14'h1000, 14'h1018, 14'h1020, 14'h1024, 14'h1028,
      14'h102c, 14'h1030, 14'h1034, 14'h2000, 14'h3ffc};
   // ************************************************
   // stimulus and observed signals
   // ************************************************
   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         dl_we = 1'b0;
   logic [13:0]  dl_addr = 14'h0000;
   logic [7:0]   dl_data = 8'h00;
   logic         dl_done = 1'b0;
   logic [7:0]   disk_present = 8'hff;
   logic [7:0]   disk_is_array = 8'h00;
   logic [255:0] disk_serial = '0;
   logic         image_valid;
   int           n_mismatch = 0;
   int           cmp_count = 0;
   int           cycles = 0;
   logic [4:0]   ops [$]; // {op, disk} of every execute i/o request
   rom_link_if link ();
   rom_device #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) rom_device_i (.pclk(pclk),
      .presetn(presetn), .link(link), .dl_we(dl_we), .dl_addr(dl_addr), .dl_data(dl_data),
      .dl_done(dl_done), .disk_present(disk_present), .disk_is_array(disk_is_array),
      .disk_serial(disk_serial), .image_valid(image_valid));
   rom_host rom_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   rom_link_asserts #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) rom_link_asserts_i (
      .pclk(pclk), .presetn(presetn), .rom_base(link.rom_base), .mem_req(link.mem_req),
      .mem_we(link.mem_we), .mem_addr(link.mem_addr), .mem_ack(link.mem_ack),
      .mem_rdata(link.mem_rdata), .io_req(link.io_req), .io_op(link.io_op),
      .io_ack(link.io_ack), .io_ok(link.io_ok));
   // ************************************************
   // clock, watchdog and link monitor
   // ************************************************
   always #5 pclk = ~pclk;
   // a hang counts as a mismatch and goes straight to the verdict
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         $display("unexpected at %0t: run did not finish", $time);
         wrap_up();
      end
      if (link.io_req === 1'b1)
         ops.push_back({link.io_op, link.io_disk});
   end
   // ************************************************
   // compares, bus cycles and expectations
   // ************************************************
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmp32
   task automatic cmp1(input logic got, input logic exp, input string what);
      cmp32({31'h0, got}, {31'h0, exp}, what);
   endtask : cmp1
   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   // read data stands through the access phase
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      apb(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      n = 0;
      s = 32'h0;
      while (s[0] !== 1'b1 && n < 60)
      begin
         rd(REG_STATUS, s);
         n++;
      end
      cmp1(s[0], 1'b1, "host idle");
   endtask : wait_idle
   task automatic rom_rd(input logic [31:0] base, input logic [31:0] o, output logic [31:0] q);
      wr(REG_ADDR, base + o);
      wait_idle();
      rd(REG_DATA, q);
   endtask : rom_rd
   // expected {mask, word} of a window word, built from the image layout
   function automatic logic [63:0] exp_word(input logic [13:0] o);
      case (o)
         14'h0000: exp_word = {32'h00ff_ffff, 8'h00, X86_UNITS, SIG_BYTE1, SIG_BYTE0};
         14'h1000: exp_word = {32'hffff_ffff, 4'h0, FCODE_OFFSET, SIG_BYTE1, SIG_BYTE0};
         14'h0018, 14'h1018: exp_word = {32'h0000_ffff, 16'h0000, 4'h0, DS_OFFSET};
         14'h0020, 14'h1020: exp_word = {32'hffff_ffff, PCIR_WORD};
         14'h0024, 14'h1024: exp_word = {32'hffff_ffff, DEVC, VEND};
         14'h0028, 14'h1028: exp_word = {32'hffff_ffff, DS_LENGTH, VPD_NONE};
         14'h002c, 14'h102c: exp_word = {32'hffff_ffff, CLASS_CODE, DS_REVISION};
         14'h0030, 14'h1030: exp_word = {32'hffff_ffff, 16'h0000, IMG_UNITS};
         14'h0034: exp_word = {32'hffff_ffff, 16'h0000, NOT_LAST, CODE_X86};
         14'h1034: exp_word = {32'hffff_ffff, 16'h0000, LAST_IMAGE, CODE_OFW};
         default: exp_word = {32'hffff_ffff, 32'hffff_ffff};
      endcase
   endfunction : exp_word
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      logic [31:0] q;
      logic [31:0] base;
      logic [63:0] e;
      logic [63:0] dlw;
      int          k;
      void'($urandom(81121));
      base = $urandom() & 32'hffff_0000;
      disk_is_array <= 8'($urandom());
      // serial low nibble is the disk index, so serials never collide
      for (int i = 0; i < 8; i++)
         disk_serial[i*32 +: 32] <= {$urandom() & 32'hffff_fff0} | 32'(i);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1 cmp1(image_valid, 1'b1, "image valid after reset");
      wr(REG_CTRL, base);
      rd(REG_CTRL, q);
      cmp32(q, base, "rom base");
      rom_rd(base, 32'h0000_4000, q);
      cmp32(q, 32'h0, "above window");
      rom_rd(base, 32'hffff_fffc, q);
      cmp32(q, 32'h0, "below window");
      foreach (OFFS[i])
      begin
         e = exp_word(OFFS[i]);
         rom_rd(base, {18'h0, OFFS[i]}, q);
         cmp32(q & e[63:32], e[31:0], "window word");
      end
      // host write hits the last word read, which must keep its ffh fill
      wr(REG_DATA, $urandom());
      wait_idle();
      rom_rd(base, 32'h0000_3ffc, q);
      cmp32(q, 32'hffff_ffff, "after host write");
      // download one word into each image
      dlw = {$urandom(), $urandom()};
      for (int b = 0; b < 8; b++)
      begin
         dl_we   <= 1'b1;
         dl_addr <= (b < 4 ? 14'h0200 : 14'h1200) + 14'(b % 4);
         dl_data <= dlw[b*8 +: 8];
         @(posedge pclk);
      end
      dl_we <= 1'b0;
      @(posedge pclk);
      #1 cmp1(image_valid, 1'b0, "valid during download");
      @(posedge pclk);
      dl_done <= 1'b1;
      @(posedge pclk);
      dl_done <= 1'b0;
      @(posedge pclk);
      #1 cmp1(image_valid, 1'b1, "valid after download");
      rom_rd(base, 32'h0200, q);
      cmp32(q, dlw[31:0], "downloaded x86 word");
      rom_rd(base, 32'h1200, q);
      cmp32(q, dlw[63:32], "downloaded fcode word");
      // boot scan; a target write while busy must be refused
      k = $urandom_range(7, 0);
      wr(REG_TARGET, disk_serial[k*32 +: 32]);
      ops.delete();
      wr(REG_SCAN, 32'h1);
      wr(REG_TARGET, ~disk_serial[k*32 +: 32]);
      wait_idle();
      rd(REG_RESULT, q);
      cmp32(q, 32'(k), "boot disk");
      rd(REG_STATUS, q);
      cmp32(q & 32'h7, 32'h7, "status after scan");
      rd(REG_SCAN, q);
      cmp32(q, 32'h8, "resource count");
      cmp32(32'(ops.size()), 32'(k + 3), "operation count");
      cmp32({30'h0, ops[0][4:3]}, {30'h0, OP_READY_TEST}, "first operation");
      for (int i = 0; i <= k; i++)
         cmp32({27'h0, ops[i+1]}, {27'h0, OP_TEST, 3'(i)}, "test operation");
      cmp32({27'h0, ops[k+2]}, {27'h0, OP_READ, 3'(k)}, "read operation");
      // no serial matches: every disk tested, no read
      wr(REG_TARGET, 32'h0000_000f);
      ops.delete();
      wr(REG_SCAN, 32'h1);
      wait_idle();
      rd(REG_STATUS, q);
      cmp32(q & 32'h2, 32'h0, "nothing found");
      cmp32(32'(ops.size()), 32'h9, "full scan count");
      wrap_up();
   end
endmodule : tb_pci_expansion_rom_image
